/* verilog/uaqp_port.sv */
`timescale 1ns/100ps
`include "uaqp_regs.svh"
// Behaviour
// - drive address bits 15..8 on the upper port during every external access except pointer-indirect data moves
// - upper port latch reaches the upper port pins only through pointer-indirect data moves, and stays there until the next external access
// - pointer-indirect data moves use the upper latch as high address byte
// - upper port bit n carries address bit n plus 8
// - reset sets every quasi port latch bit to one, weak pull-up only
// - latch one means input: pin is sensed, outside may pull it low
// - writing zero turns on strong pull-down until one is written or reset
// - zero to one change gives brief strong high drive, then weak pull-up
// - quasi bit 0 is serial receive input, bit 1 serial transmit output
// - adjacent bit 6 is interrupt four, detected on rising edge
// - adjacent bit 7 is interrupt five, detected on falling edge
// - bit 4 timer zero input, bit 5 timer one input and clock output
// - bit 6 external write strobe, bit 7 external read strobe
module uaqp_port
  import uaqp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  // latch writes from the core
  input  wire logic             upper_latch_we_i,
  input  wire logic [WIDTH-1:0] upper_latch_wdata_i,
  input  wire logic             quasi_latch_we_i,
  input  wire logic [WIDTH-1:0] quasi_latch_wdata_i,
  // external memory access from the core
  input  wire logic             mem_access_i,
  input  wire logic             external_data_move_i,
  input  wire logic [WIDTH-1:0] mem_addr_hi_i,
  // alternate outputs from peripherals
  input  wire uaqp_alt_out_t    alt_out_i,
  // quasi port pins
  input  wire logic [WIDTH-1:0] quasi_pin_i,
  output logic      [WIDTH-1:0] quasi_pin_o,
  output logic      [WIDTH-1:0] quasi_pin_oe_o,
  // adjacent port pins 6 and 7
  input  wire logic [1:0]       adj_pin_i,
  // upper address pins
  output logic      [WIDTH-1:0] upper_address_byte_o,
  // readback and peripheral inputs to the core
  output logic      [WIDTH-1:0] upper_latch_o,
  output logic      [WIDTH-1:0] quasi_latch_o,
  output logic      [WIDTH-1:0] quasi_pin_level_o,
  output uaqp_alt_in_t          alt_in_o,
  output logic                  rising_edge_irq_four_o,
  output logic                  falling_edge_irq_five_o
);

  localparam int STRONG_CYC_RAW = (`UAQP_STRONG_NS + `UAQP_CLK_NS - 1) / `UAQP_CLK_NS;
  localparam int STRONG_CYC     = (STRONG_CYC_RAW < 1) ? 1 : STRONG_CYC_RAW;
  localparam int CW             = $clog2(STRONG_CYC + 1);

  logic [WIDTH-1:0] upper_latch_q;
  logic [WIDTH-1:0] quasi_latch_q;
  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;
  logic [1:0]       adj1_q;
  logic [1:0]       adj2_q;
  logic [1:0]       adj3_q;
  logic [WIDTH-1:0] alt_vec;
  logic [WIDTH-1:0] eff_d;
  logic [WIDTH-1:0] eff_q;
  logic [WIDTH-1:0] strong_hi;

  // map alternate outputs onto quasi bit positions, idle bits high
  function automatic logic [WIDTH-1:0] alt_map(input uaqp_alt_out_t a);
    logic [WIDTH-1:0] v;
    v = '1;
    v[`UAQP_BIT_TXD]   = a.serial_zero_transmit;
    v[`UAQP_BIT_T1CLK] = a.clock_out_en ? a.clock_out : 1'b1;
    v[`UAQP_BIT_WRS]   = a.write_strobe_n;
    v[`UAQP_BIT_RDS]   = a.read_strobe_n;
    return v;
  endfunction : alt_map

  // one-cycle edge flag from the current and the previous synchronised level
  function automatic logic edge_seen(input logic now_lvl, input logic old_lvl, input logic rising);
    return rising ? (now_lvl & ~old_lvl) : (~now_lvl & old_lvl);
  endfunction : edge_seen

  // upper latch, held for pointer-indirect moves only
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upper_latch_q <= `UAQP_LATCH_RST;
    end else if (upper_latch_we_i) begin
      upper_latch_q <= upper_latch_wdata_i;
    end
  end

  // upper address pins: memory address bits, or the latch value during external data moves
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upper_address_byte_o <= `UAQP_ADDR_RST;
    end else if (mem_access_i && external_data_move_i) begin
      upper_address_byte_o <= upper_latch_q;
    end else if (mem_access_i) begin
      upper_address_byte_o <= mem_addr_hi_i;
    end
  end

  // quasi port latch, all ones at reset, zero held until a one is written
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      quasi_latch_q <= `UAQP_LATCH_RST;
    end else if (quasi_latch_we_i) begin
      quasi_latch_q <= quasi_latch_wdata_i;
    end
  end

  // effective output level combines latch and alternate output
  assign alt_vec = alt_map(alt_out_i);
  assign eff_d   = quasi_latch_q & alt_vec;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eff_q <= `UAQP_LATCH_RST;
    end else begin
      eff_q <= eff_d;
    end
  end

  // per-bit strong high pulse on a zero to one change
  for (genvar i = 0; i < WIDTH; i++) begin : g_strong
    logic [CW-1:0] cnt_q;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        cnt_q <= '0;
      end else if (!eff_d[i]) begin
        cnt_q <= '0;
      end else if (!eff_q[i]) begin
        cnt_q <= CW'(STRONG_CYC);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
    assign strong_hi[i] = eff_d[i] && (!eff_q[i] || (cnt_q > CW'(1)));
  end

  // pin drive value follows the effective level
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      quasi_pin_o <= '1;
    end else begin
      quasi_pin_o <= eff_d;
    end
  end

  // strong drive: low for zero, brief high after a rise, else weak pull-up
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      quasi_pin_oe_o <= '0;
    end else begin
      quasi_pin_oe_o <= ~eff_d | strong_hi;
    end
  end

  // two-stage synchroniser for the quasi port pins
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= quasi_pin_i;
      sync2_q <= sync1_q;
    end
  end

  // adjacent pins: two synchroniser stages plus one history stage for edges
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      adj1_q <= '1;
      adj2_q <= '1;
      adj3_q <= '1;
    end else begin
      adj1_q <= adj_pin_i;
      adj2_q <= adj1_q;
      adj3_q <= adj2_q;
    end
  end

  // sensed pin levels to the core
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      quasi_pin_level_o <= '1;
    end else begin
      quasi_pin_level_o <= sync2_q;
    end
  end

  // alternate inputs to the core peripherals
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alt_in_o <= '1;
    end else begin
      alt_in_o.serial_zero_receive    <= sync2_q[`UAQP_BIT_RXD];
      alt_in_o.external_irq_zero      <= sync2_q[`UAQP_BIT_IRQ0];
      alt_in_o.external_irq_one       <= sync2_q[`UAQP_BIT_IRQ1];
      alt_in_o.timer_zero_count_input <= sync2_q[`UAQP_BIT_TMR0];
      alt_in_o.timer_one_input        <= sync2_q[`UAQP_BIT_T1CLK];
    end
  end

  // rising edge of adjacent pin 6 gives a one-cycle interrupt four pulse
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rising_edge_irq_four_o <= 1'b0;
    end else begin
      rising_edge_irq_four_o <= edge_seen(adj2_q[`UAQP_ADJ_IRQ4], adj3_q[`UAQP_ADJ_IRQ4], 1'b1);
    end
  end

  // falling edge of adjacent pin 7 gives a one-cycle interrupt five pulse
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      falling_edge_irq_five_o <= 1'b0;
    end else begin
      falling_edge_irq_five_o <= edge_seen(adj2_q[`UAQP_ADJ_IRQ5], adj3_q[`UAQP_ADJ_IRQ5], 1'b0);
    end
  end

  // latch readback
  assign upper_latch_o = upper_latch_q;
  assign quasi_latch_o = quasi_latch_q;

endmodule : uaqp_port

/* shared/uaqp_regs.svh */
`ifndef UAQP_REGS_SVH
`define UAQP_REGS_SVH
// port latch state after reset
`define UAQP_LATCH_RST   8'hff
// upper address state after reset
`define UAQP_ADDR_RST    8'h00
// quasi port bit positions of the alternate functions
`define UAQP_BIT_RXD     0
`define UAQP_BIT_TXD     1
`define UAQP_BIT_IRQ0    2
`define UAQP_BIT_IRQ1    3
`define UAQP_BIT_TMR0    4
`define UAQP_BIT_T1CLK   5
`define UAQP_BIT_WRS     6
`define UAQP_BIT_RDS     7
// adjacent port bit positions of the edge interrupts
`define UAQP_ADJ_IRQ4    0
`define UAQP_ADJ_IRQ5    1
// timing: strong pull-up pulse length and clock period in ns
`define UAQP_STRONG_NS   25
`define UAQP_CLK_NS      25
`endif

/* shared/uaqp_pkg.sv */
package uaqp_pkg;
  // alternate output functions coming from the core peripherals
  typedef struct packed {
    logic serial_zero_transmit;
    logic clock_out;
    logic clock_out_en;
    logic write_strobe_n;
    logic read_strobe_n;
  } uaqp_alt_out_t;
  // alternate input functions going to the core peripherals
  typedef struct packed {
    logic serial_zero_receive;
    logic external_irq_zero;
    logic external_irq_one;
    logic timer_zero_count_input;
    logic timer_one_input;
  } uaqp_alt_in_t;
endpackage : uaqp_pkg

/* sim/uaqp_pin_model.sv */
`timescale 1ns/100ps
module uaqp_pin_model (
  // port drive and outside pull-down
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] low_i,
  // resolved pin levels
  output logic      [7:0] pin_o
);
  // strong drive wins, else weak pull-up unless held low outside
  assign pin_o = (oe_i & drv_i) | (~oe_i & ~low_i);
endmodule : uaqp_pin_model

/* sim/uaqp_port_checker.sv */
`timescale 1ns/100ps
module uaqp_port_checker
  import uaqp_pkg::*;
#(parameter int WIDTH = 8) (
  // clock and reset
  input wire logic             mclk_i,
  input wire logic             rstn_i,
  // watched inputs
  input wire logic             mem_access_i,
  input wire logic             external_data_move_i,
  input wire logic [WIDTH-1:0] mem_addr_hi_i,
  input wire uaqp_alt_out_t    alt_out_i,
  input wire logic [1:0]       adj_pin_i,
  // watched outputs
  input wire logic [WIDTH-1:0] upper_address_byte_o,
  input wire logic [WIDTH-1:0] upper_latch_o,
  input wire logic [WIDTH-1:0] quasi_latch_o,
  input wire logic [WIDTH-1:0] quasi_pin_o,
  input wire logic [WIDTH-1:0] quasi_pin_oe_o,
  input wire logic             rising_edge_irq_four_o,
  input wire logic             falling_edge_irq_five_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // upper address pins
  addr_follow_a: assert property (
    mem_access_i && !external_data_move_i |=> upper_address_byte_o == $past(mem_addr_hi_i)) else $error("address");
  data_move_a: assert property (
    mem_access_i && external_data_move_i |=> upper_address_byte_o == $past(upper_latch_o)) else $error("move");
  addr_hold_a: assert property (
    !mem_access_i |=> $stable(upper_address_byte_o)) else $error("hold");
  // quasi pin drive and edge pulses
  pull_down_a: assert property (
    !quasi_latch_o[0] |=> quasi_pin_oe_o[0] && !quasi_pin_o[0]) else $error("pull down");
  strong_high_a: assert property (
    $rose(quasi_latch_o[0]) |=> quasi_pin_oe_o[0] && quasi_pin_o[0] ##1 !quasi_pin_oe_o[0]) else $error("high");
  write_strobe_a: assert property (
    !alt_out_i.write_strobe_n |=> quasi_pin_oe_o[6] && !quasi_pin_o[6]) else $error("strobe");
  irq_four_a: assert property (
    $rose(adj_pin_i[0]) |-> ##[1:4] rising_edge_irq_four_o ##1 !rising_edge_irq_four_o) else $error("irq four");
  irq_five_a: assert property (
    $fell(adj_pin_i[1]) |-> ##[1:4] falling_edge_irq_five_o ##1 !falling_edge_irq_five_o) else $error("irq five");
endmodule : uaqp_port_checker

/* sim/uaqp_port_tb.sv */
`timescale 1ns/100ps
`include "uaqp_regs.svh"
module uaqp_port_tb;
  import uaqp_pkg::*;
  logic mclk_i = 0, rstn_i = 0, ulwe = 0, qlwe = 0, acc = 0, mv = 0, r4, f5;
  logic [7:0] ulw = 0, qlw = 0, ahi = 0, xl = 0, d, a, e, qo, qoe, ua, ql, lvl, pin, ul, p;
  logic [3:0] n4 = 0, n5 = 0;
  logic [1:0] adj = 2'h2;
  uaqp_alt_out_t alt = 5'h1b;
  uaqp_alt_in_t ain;
  int num_errors = 0, n_tests = 0, cyc = 0, seed = 32'h1e28, k;
  // design and the outside pins
  uaqp_port uaqp_port_i (.mclk_i, .rstn_i, .upper_latch_we_i(ulwe), .upper_latch_wdata_i(ulw),
    .quasi_latch_we_i(qlwe), .quasi_latch_wdata_i(qlw), .mem_access_i(acc), .external_data_move_i(mv),
    .mem_addr_hi_i(ahi), .alt_out_i(alt), .quasi_pin_i(pin), .quasi_pin_o(qo), .quasi_pin_oe_o(qoe),
    .adj_pin_i(adj), .upper_address_byte_o(ua), .upper_latch_o(ul), .quasi_latch_o(ql), .quasi_pin_level_o(lvl),
    .alt_in_o(ain), .rising_edge_irq_four_o(r4), .falling_edge_irq_five_o(f5));
  uaqp_pin_model uaqp_pin_model_i (.drv_i(qo), .oe_i(qoe), .low_i(xl), .pin_o(pin));
  // clock
  always #12.5 mclk_i = ~mclk_i;
  // pulse counters and hang guard
  always @(posedge mclk_i) begin
    {n4, n5} <= {n4 + 4'(r4), n5 + 4'(f5)};
    cyc++;
    if (cyc == 2000) close_out(1);
  end
  // expected drive: latch anded with the alternate outputs
  function automatic logic [7:0] eff_f(input logic [7:0] l, input uaqp_alt_out_t t);
    return l & {t.read_strobe_n, t.write_strobe_n, t.clock_out | ~t.clock_out_en, 3'h7, t.serial_zero_transmit, 1'h1};
  endfunction : eff_f
  // compare and count
  task automatic chk(input logic [7:0] seen, exp);
    n_tests++;
    num_errors += int'(seen !== exp);
    if (seen !== exp) $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
  endtask : chk
  // counts, verdict and end of run
  task automatic close_out(input int hung);
    num_errors += hung;
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // reset, address, pin drive and edge interrupt cases
  initial begin
    repeat (2) @(negedge mclk_i);
    chk(ql & ~qoe, 8'hff);
    @(posedge mclk_i);
    rstn_i <= 1;
    for (k = 0; k < 8; k++) begin
      {a, d} = 16'($random(seed));
      @(posedge mclk_i);
      {ulwe, ulw} <= {1'h1, d};
      @(posedge mclk_i);
      {ulwe, acc, mv, ahi} <= {2'h1, k[0], a};
      @(posedge mclk_i);
      {acc, mv, ahi} <= {2'h0, ~a};
      repeat (3) @(negedge mclk_i);
      chk(ua, k[0] ? d : a);
      chk(ul, d);
    end
    for (k = 0; k < 16; k++) begin
      d = k ? 8'($random(seed)) : 8'h00;
      p = ql;
      @(posedge mclk_i);
      {qlwe, qlw, alt, xl} <= {1'h1, d, 13'($random(seed))};
      @(posedge mclk_i);
      qlwe <= 1'h0;
      e = eff_f(d, alt);
      a = e & ~xl;
      repeat (2) @(negedge mclk_i);
      chk(qoe, ~(e & p));
      repeat (6) @(negedge mclk_i);
      chk(ql, d);
      chk(qo, e);
      chk(qoe, ~e);
      chk(lvl, a);
      chk(8'(ain), {3'h0, a[0], a[2], a[3], a[4], a[5]});
    end
    // mid-run reset over a random latch value and alternate outputs
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    @(negedge mclk_i);
    chk(ql, `UAQP_LATCH_RST);
    chk(qoe, 8'h00);
    @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(qoe, ~eff_f(`UAQP_LATCH_RST, alt));
    for (k = 0; k < 2; k++) begin
      @(posedge mclk_i);
      adj <= k ? 2'h2 : 2'h1;
      repeat (8) @(negedge mclk_i);
      chk({n4, n5}, 8'h11);
    end
    close_out(0);
  end
endmodule : uaqp_port_tb
bind uaqp_port uaqp_port_checker #(.WIDTH(WIDTH)) uaqp_port_checker_i (.*);
